// *** mask_status_pkg.sv ***
// register map, field positions and reset values of the mask/status bank
// assumes a byte-wide command/data register port from the serial engine
package mask_status_pkg;
  // command codes
  localparam logic [7:0] ALERT_SUPPRESS_CMD = 8'hf9;
  localparam logic [7:0] FAULT_SUPPRESS_CMD = 8'hfa;
  localparam logic [7:0] GENERAL_CONDITION_CMD = 8'hfb;
  localparam logic [7:0] PHASE_ENABLE_REPORT_CMD = 8'hfc;
  // reset values
  localparam logic [7:0] ALERT_SUPPRESS_RST = 8'h00;
  localparam logic [7:0] FAULT_SUPPRESS_RST = 8'h00;
  // writable bits of each mask
  localparam logic [7:0] ALERT_SUPPRESS_WMASK = 8'h0d;
  localparam logic [7:0] FAULT_SUPPRESS_WMASK = 8'hcd;
  // mask bit positions
  localparam int OUTPUT_VOLTAGE_SUPPRESS_BIT = 7;
  localparam int OUTPUT_CURRENT_SUPPRESS_BIT = 6;
  localparam int COMM_LOGIC_SUPPRESS_BIT = 3;
  localparam int MONITORED_VOLTAGE_SUPPRESS_BIT = 2;
  localparam int OUTPUT_POWER_SUPPRESS_BIT = 0;
  // general condition bits
  localparam int GC_FAULT_BIT = 7;
  localparam int GC_ALERT_BIT = 6;
  localparam int GC_POWER_GOOD_BIT = 5;
  localparam int GC_READY_BIT = 4;
  // phase report bits
  localparam int PR_PHASE4_BIT = 5;
  localparam int PR_PHASE3_BIT = 4;
  localparam int PR_PHASE2_BIT = 3;
  localparam int PR_POWER_SAVE_BIT = 2;
endpackage : mask_status_pkg

// *** pin_sync.sv ***
// two-flop synchroniser for a bus of asynchronous levels
// assumes one clock domain at the destination
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** alert_fault_mask_status_regs.sv ***
// mask and status register bank of a multi-phase buck controller
// assumes the serial engine delivers byte writes/reads by command code
`timescale 1ns/1ns
`default_nettype none
module alert_fault_mask_status_regs
  import mask_status_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register port from serial engine
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // status sources, same clock
  input wire logic output_voltage_flag_i,
  input wire logic output_current_flag_i,
  input wire logic comm_logic_flag_i,
  input wire logic monitored_voltage_flag_i,
  input wire logic output_power_flag_i,
  input wire logic power_good_i,
  input wire logic ready_i,
  input wire logic [2:0] phase_enable_i,
  // pin, asynchronous, active low
  input wire logic power_save_input_n_i,
  // signalling outputs
  output logic fault_o,
  output logic alert_o,
  output logic [7:0] alert_suppress_o,
  output logic [7:0] fault_suppress_o
);
  logic [7:0] alert_suppress_q;
  logic [7:0] fault_suppress_q;
  logic power_save_raw;
  logic power_save_sync;
  logic [7:0] general_condition;
  logic [7:0] phase_enable_report;
  logic [7:0] rdata_d;
  logic alert_d;
  logic fault_d;
  logic cmd_known;

  // inverted ahead of the flops: their reset value then means not
  // asserted, so no false power-save report shows around reset
  assign power_save_raw = ~power_save_input_n_i;

  // pin passes two flops before use
  pin_sync #(.WIDTH(1)) u_power_save_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(power_save_raw),
    .sync_o(power_save_sync)
  );

  // alert gating by each suppress bit
  assign alert_d =
    (comm_logic_flag_i & ~alert_suppress_q[COMM_LOGIC_SUPPRESS_BIT])
    | (monitored_voltage_flag_i
       & ~alert_suppress_q[MONITORED_VOLTAGE_SUPPRESS_BIT]
       & ~fault_suppress_q[MONITORED_VOLTAGE_SUPPRESS_BIT])
    | (output_power_flag_i
       & ~alert_suppress_q[OUTPUT_POWER_SUPPRESS_BIT]);

  // fault gating; monitored voltage is alert-only
  assign fault_d =
    (output_voltage_flag_i
     & ~fault_suppress_q[OUTPUT_VOLTAGE_SUPPRESS_BIT])
    | (output_current_flag_i
       & ~fault_suppress_q[OUTPUT_CURRENT_SUPPRESS_BIT])
    | (comm_logic_flag_i
       & ~fault_suppress_q[COMM_LOGIC_SUPPRESS_BIT])
    | (output_power_flag_i
       & ~fault_suppress_q[OUTPUT_POWER_SUPPRESS_BIT]);

  // status images; general condition low nibble and phase report bits 7:6 and 1:0 read zero
  assign general_condition = {fault_o, alert_o, power_good_i, ready_i,
                              4'h0};
  assign phase_enable_report = {2'h0, phase_enable_i,
                                power_save_sync, 2'h0};

  // read decode; unknown codes read zero
  assign cmd_known = (cmd_i == ALERT_SUPPRESS_CMD)
                     | (cmd_i == FAULT_SUPPRESS_CMD)
                     | (cmd_i == GENERAL_CONDITION_CMD)
                     | (cmd_i == PHASE_ENABLE_REPORT_CMD);
  assign rdata_d =
    (cmd_i == ALERT_SUPPRESS_CMD) ? alert_suppress_q :
    (cmd_i == FAULT_SUPPRESS_CMD) ? fault_suppress_q :
    (cmd_i == GENERAL_CONDITION_CMD) ? general_condition :
    (cmd_i == PHASE_ENABLE_REPORT_CMD) ? phase_enable_report :
    8'h00;

  // mask registers; status codes have no write path
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      alert_suppress_q <= ALERT_SUPPRESS_RST;
      fault_suppress_q <= FAULT_SUPPRESS_RST;
    end else if (wr_en_i) begin
      if (cmd_i == ALERT_SUPPRESS_CMD)
        alert_suppress_q <= wdata_i & ALERT_SUPPRESS_WMASK;
      if (cmd_i == FAULT_SUPPRESS_CMD)
        fault_suppress_q <= wdata_i & FAULT_SUPPRESS_WMASK;
    end
  end

  // registered outputs; signalling lags its cause by one cycle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      alert_o <= 1'b0;
      fault_o <= 1'b0;
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
      alert_suppress_o <= ALERT_SUPPRESS_RST;
      fault_suppress_o <= FAULT_SUPPRESS_RST;
    end else begin
      alert_o <= alert_d;
      fault_o <= fault_d;
      rvalid_o <= rd_en_i;
      rdata_o <= rd_en_i ? rdata_d : 8'h00;
      alert_suppress_o <= alert_suppress_q;
      fault_suppress_o <= fault_suppress_q;
    end
  end

  // checks; a masked source is tested alone, since any other unmasked
  // source may legally keep the shared output high
  comm_alert_mask_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    comm_logic_flag_i && alert_suppress_q[COMM_LOGIC_SUPPRESS_BIT]
    && !monitored_voltage_flag_i && !output_power_flag_i |=> !alert_o)
    else $error("alert seen despite comm mask");
  monitor_alert_mask_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    monitored_voltage_flag_i && !comm_logic_flag_i && !output_power_flag_i
    && (alert_suppress_q[2] || fault_suppress_q[2]) |=> !alert_o)
    else $error("monitored voltage alert not masked");
  power_alert_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_power_flag_i && !alert_suppress_q[0] |=> alert_o)
    else $error("unmasked power alert missing");
  power_alert_hide_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_power_flag_i && alert_suppress_q[OUTPUT_POWER_SUPPRESS_BIT]
    && !comm_logic_flag_i && !monitored_voltage_flag_i |=> !alert_o)
    else $error("power alert seen despite mask");
  fault_reset_val_a: assert property (@(posedge core_clk_i)
    $rose(rstn_i) |-> fault_suppress_q == 8'h00)
    else $error("fault mask reset value wrong");
  voltage_fault_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_voltage_flag_i && !fault_suppress_q[7] |=> fault_o)
    else $error("voltage fault missing");
  voltage_fault_hide_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_voltage_flag_i
    && fault_suppress_q[OUTPUT_VOLTAGE_SUPPRESS_BIT]
    && !output_current_flag_i && !comm_logic_flag_i
    && !output_power_flag_i |=> !fault_o)
    else $error("voltage fault seen despite mask");
  current_fault_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_current_flag_i && !fault_suppress_q[6] |=> fault_o)
    else $error("current fault missing");
  current_fault_hide_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_current_flag_i
    && fault_suppress_q[OUTPUT_CURRENT_SUPPRESS_BIT]
    && !output_voltage_flag_i && !comm_logic_flag_i
    && !output_power_flag_i |=> !fault_o)
    else $error("current fault seen despite mask");
  comm_fault_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    comm_logic_flag_i && !fault_suppress_q[3] |=> fault_o)
    else $error("comm logic fault missing");
  comm_fault_hide_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    comm_logic_flag_i
    && fault_suppress_q[COMM_LOGIC_SUPPRESS_BIT]
    && !output_voltage_flag_i && !output_current_flag_i
    && !output_power_flag_i |=> !fault_o)
    else $error("comm logic fault seen despite mask");
  power_fault_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_power_flag_i && !fault_suppress_q[OUTPUT_POWER_SUPPRESS_BIT]
    |=> fault_o)
    else $error("unmasked power fault missing");
  power_fault_hide_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    output_power_flag_i
    && fault_suppress_q[OUTPUT_POWER_SUPPRESS_BIT]
    && !output_voltage_flag_i && !output_current_flag_i
    && !comm_logic_flag_i |=> !fault_o)
    else $error("power fault seen despite mask");
  status_read_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    rd_en_i && cmd_i == GENERAL_CONDITION_CMD
    |=> rvalid_o && rdata_o[3:0] == 4'h0 && rdata_o[7] == $past(fault_o))
    else $error("general condition read wrong");
  phase_read_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    rd_en_i && cmd_i == PHASE_ENABLE_REPORT_CMD
    |=> rdata_o[5:3] == $past(phase_enable_i) && rdata_o[7:6] == 2'h0)
    else $error("phase report read wrong");
  power_save_read_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    rd_en_i && cmd_i == PHASE_ENABLE_REPORT_CMD
    |=> rdata_o[2] == $past(power_save_sync) && rdata_o[1:0] == 2'h0)
    else $error("power save report read wrong");
  unknown_read_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    rd_en_i && !cmd_known |=> rvalid_o && rdata_o == 8'h00)
    else $error("unknown code read not zero");
  status_write_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    wr_en_i && (cmd_i == GENERAL_CONDITION_CMD
    || cmd_i == PHASE_ENABLE_REPORT_CMD)
    |=> $stable(alert_suppress_q) && $stable(fault_suppress_q))
    else $error("mask changed by status write");
  ro_write_a: assert property (@(posedge core_clk_i)
    disable iff (!rstn_i)
    wr_en_i && cmd_i != FAULT_SUPPRESS_CMD |=> $stable(fault_suppress_q))
    else $error("fault mask changed by foreign write");
endmodule : alert_fault_mask_status_regs
`default_nettype wire

// *** reg_host.sv ***
// register port driver standing in for the serial engine on the host side
// assumes strobes are sampled on the rising edge and driven at the falling
`timescale 1ns/1ns
`default_nettype none
module reg_host (
  // clock
  input wire logic core_clk_i,
  // register port
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] cmd_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  // idle strobes low before reset is released
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    cmd_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one-byte write; released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge core_clk_i);
    wr_en_o = 1'b1;
    cmd_o = cmd;
    wdata_o = data;
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    cmd_o = ~cmd;
    wdata_o = ~data;
  endtask : wr
  // one-byte read; ok stays low if no answer comes within four cycles
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data,
                    output logic ok);
    ok = 1'b0;
    data = 8'h00;
    @(negedge core_clk_i);
    rd_en_o = 1'b1;
    cmd_o = cmd;
    @(negedge core_clk_i);
    rd_en_o = 1'b0;
    cmd_o = ~cmd;
    for (int k = 0; k < 4 && !ok; k++) begin
      if (rvalid_i === 1'b1) begin
        data = rdata_i;
        ok = 1'b1;
      end else begin
        @(negedge core_clk_i);
      end
    end
  endtask : rd
endmodule : reg_host
`default_nettype wire

// *** tb_alert_fault_mask_status_regs.sv ***
// self-checking bench of the mask and status register bank
// assumes reg_host drives the register port; flags change at falling edges
`timescale 1ns/1ns
`default_nettype none
module tb_alert_fault_mask_status_regs;
  import mask_status_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wr_en, rd_en, rvalid, fault_o, alert_o, pg = 1'b0, rdy = 1'b0;
  logic psn = 1'b1;
  logic [7:0] cmd, wdata, rdata, asup, fsup;
  logic [4:0] flg = 5'h00;
  logic [2:0] phase = 3'h0;
  int fail_count = 0;
  int samples_checked = 0;
  // per source: flag, expected {fault, alert}, alert mask, fault mask
  logic [4:0] fl [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h02, 5'h01};
  logic [1:0] fa [6] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h1, 2'h3};
  logic [7:0] am [6] = '{8'h00, 8'h00, 8'h08, 8'h04, 8'h00, 8'h01};
  logic [7:0] fm [6] = '{8'h80, 8'h40, 8'h08, 8'h00, 8'h04, 8'h01};
  always #4 core_clk_i = ~core_clk_i;
  reg_host h (.core_clk_i(core_clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .cmd_o(cmd), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
  alert_fault_mask_status_regs dut (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .cmd_i(cmd),
    .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .output_voltage_flag_i(flg[4]), .output_current_flag_i(flg[3]),
    .comm_logic_flag_i(flg[2]), .monitored_voltage_flag_i(flg[1]),
    .output_power_flag_i(flg[0]), .power_good_i(pg), .ready_i(rdy),
    .phase_enable_i(phase), .power_save_input_n_i(psn),
    .fault_o(fault_o), .alert_o(alert_o), .alert_suppress_o(asup),
    .fault_suppress_o(fsup));
  // counts and verdict, the only place the run ends
  task automatic end_of_test;
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  // a read that never answers is a mismatch and ends the run
  task automatic rdc(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    h.rd(c, d, ok);
    if (!ok) begin
      $display("ERROR %0t read got no answer", $time);
      fail_count++;
      end_of_test();
    end else begin
      chk(d, exp);
    end
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  initial begin
    cyc(8);
    rstn_i = 1'b1;
    rdc(FAULT_SUPPRESS_CMD, 8'h00);
    rdc(ALERT_SUPPRESS_CMD, 8'h00);
    rdc(PHASE_ENABLE_REPORT_CMD, 8'h00);
    // status codes take no write; reserved mask bits stay zero
    h.wr(GENERAL_CONDITION_CMD, 8'hff);
    h.wr(PHASE_ENABLE_REPORT_CMD, 8'hff);
    h.wr(FAULT_SUPPRESS_CMD, 8'hff);
    h.wr(ALERT_SUPPRESS_CMD, 8'hff);
    rdc(GENERAL_CONDITION_CMD, 8'h00);
    rdc(PHASE_ENABLE_REPORT_CMD, 8'h00);
    rdc(FAULT_SUPPRESS_CMD, 8'hcd);
    rdc(ALERT_SUPPRESS_CMD, 8'h0d);
    rdc(8'h10, 8'h00);
    // each source raises its outputs, then its own mask bit hides it
    for (int i = 0; i < 6; i++) begin
      h.wr(ALERT_SUPPRESS_CMD, 8'h00);
      h.wr(FAULT_SUPPRESS_CMD, 8'h00);
      flg = fl[i];
      pg = i[0];
      rdy = i[1];
      cyc(3);
      chk({6'h00, fault_o, alert_o}, {6'h00, fa[i]});
      rdc(GENERAL_CONDITION_CMD, {fa[i], pg, rdy, 4'h0});
      h.wr(ALERT_SUPPRESS_CMD, am[i]);
      h.wr(FAULT_SUPPRESS_CMD, fm[i]);
      cyc(3);
      chk(fsup, fm[i]);
      chk(asup, am[i]);
      chk({6'h00, fault_o, alert_o}, 8'h00);
    end
    flg = 5'h00;
    // phase enables and the synced power-save pin
    phase = 3'h5;
    psn = 1'b0;
    cyc(4);
    rdc(PHASE_ENABLE_REPORT_CMD, 8'h2c);
    phase = 3'h2;
    psn = 1'b1;
    cyc(4);
    rdc(PHASE_ENABLE_REPORT_CMD, 8'h10);
    end_of_test();
  end
endmodule : tb_alert_fault_mask_status_regs
`default_nettype wire
